/* logic/txfp_pkg.sv */
// constants and types shared by the transmit fifo, formatter and packer
package txfp_pkg;
  localparam int DEPTH = 256;
  localparam int AW = 8;
  localparam int PW = 9;
  localparam int EW = 14;
  localparam int DW = 10;
  localparam logic [PW-1:0] HALF_LEVEL = 9'h080;
  localparam logic [PW-1:0] FULL_LEVEL = 9'h100;
  // fifo entry layout
  localparam int F_SC = 10;
  localparam int F_SVS = 11;
  localparam int F_SOC = 12;
  // qualifier codes {start of cell, special select, violation}
  localparam logic [2:0] Q_DATA = 3'h0;
  localparam logic [2:0] Q_CMD = 3'h2;
  localparam logic [2:0] Q_SOC = 3'h4;
  localparam logic [2:0] Q_EXT = 3'h6;
  localparam logic [2:0] Q_ADDR = 3'h7;
  // special character codes, Cx.y as {y[2:0], x[4:0]}
  localparam logic [7:0] CODE_EXC = 8'hE0;
  localparam logic [7:0] CODE_SOC = 8'h08;
  localparam logic [7:0] CODE_EXT = 8'h09;
  localparam logic [7:0] CODE_ADDR = 8'h0A;
  localparam logic [7:0] CODE_FILL = 8'h05;
  // packer residue counts and encoder buffer depth
  localparam logic [3:0] NB_STEP = 4'h2;
  localparam logic [3:0] NB_FULL = 4'h8;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  typedef enum logic [1:0] {ST_FETCH, ST_MARK, ST_FILL} txfp_state_t;
endpackage

/* logic/txfp_fifo.sv */
// 256 x 14 transmit fifo with gray pointers and level flags
`timescale 1ns/100ps
module txfp_fifo
  import txfp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wrEn,
  input wire logic [txfp_pkg::EW-1:0] wrData,
  input wire logic rdEn,
  output logic [txfp_pkg::EW-1:0] rdData,
  output logic rdEmpty,
  output logic emptyFlag,
  output logic halfFlag,
  output logic fullFlag
);
  import txfp_pkg::*;

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
    begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction

  logic [EW-1:0] mem [DEPTH];
  logic [PW-1:0] wrBin_r;
  logic [PW-1:0] rdBin_r;
  logic [PW-1:0] wrGray_r;
  logic [PW-1:0] rdGray_r;
  logic [PW-1:0] rdSync1_r;
  logic [PW-1:0] rdSync2_r;
  logic [PW-1:0] wrSync1_r;
  logic [PW-1:0] wrSync2_r;
  logic [PW-1:0] wrCount;
  logic [PW-1:0] wrBin_nxt;
  logic [PW-1:0] rdBin_nxt;
  logic wrOk;
  logic rdOk;

  // counts from the synchronised far pointer are pessimistic, never unsafe
  assign wrCount = wrBin_r - gray2bin(rdSync2_r);
  assign fullFlag = (wrCount == FULL_LEVEL);
  assign halfFlag = (wrCount >= HALF_LEVEL);
  assign emptyFlag = (wrCount == '0);
  assign rdEmpty = (rdBin_r == gray2bin(wrSync2_r));
  assign wrOk = wrEn && !fullFlag;
  assign rdOk = rdEn && !rdEmpty;
  assign wrBin_nxt = wrBin_r + PW'(1);
  assign rdBin_nxt = rdBin_r + PW'(1);
  assign rdData = mem[rdBin_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (wrOk)
      mem[wrBin_r[AW-1:0]] <= wrData;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wrBin_r <= '0;
      wrGray_r <= '0;
    end
    else if (wrOk)
    begin
      wrBin_r <= wrBin_nxt;
      wrGray_r <= wrBin_nxt ^ (wrBin_nxt >> 1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdBin_r <= '0;
      rdGray_r <= '0;
    end
    else if (rdOk)
    begin
      rdBin_r <= rdBin_nxt;
      rdGray_r <= rdBin_nxt ^ (rdBin_nxt >> 1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdSync1_r <= '0;
      rdSync2_r <= '0;
      wrSync1_r <= '0;
      wrSync2_r <= '0;
    end
    else
    begin
      rdSync1_r <= rdGray_r;
      rdSync2_r <= rdSync1_r;
      wrSync1_r <= wrGray_r;
      wrSync2_r <= wrSync1_r;
    end
  end

  AST_FULL_BLOCKS: assert property (@(posedge clk) disable iff (!rstn)
    fullFlag && wrEn |=> wrBin_r == $past(wrBin_r))
    else $error("write accepted while fifo full");

  AST_EMPTY_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    rdEmpty |=> rdBin_r == $past(rdBin_r))
    else $error("read accepted while fifo empty");
endmodule

/* logic/txfp_formatter.sv */
// transmit write interface, formatter, byte packer and encoder buffer
// Overview of operation
// - cascade model: empty, full flags and write enable are active high
// - cascade model: data captured one clock after the write enable
// - convention select high picks cascade, same address and select steps
// - fifo holds 256 entries of 14 bits, data plus qualifiers
// - entry written only when selected and enable sampled asserted
// - full, half-full and empty flags updated on the write clock
// - all fifo reads come from the formatter state machine
// - qualifiers interpreted only with fifo and encoder both enabled
// - qualifiers 000 and 010 encode data or command normally
// - qualifiers 001, 011, 101 replace the character with C0.7
// - qualifier 100 sends C8.0 then the character
// - qualifier 110 sends C9.0 then the character
// - qualifier 111 sends C10.0 then the character
// - a character after a marker is always sent as data
// - ten-bit packing only while the fifo is enabled
// - four ten-bit words travel in exactly five bytes
// - byte order A lo, B+A, C+B, D+C, D hi, then repeat
// - fifo empty with bits pending: pad the byte and send it
// - padded byte followed by C5.0 and sequencer back to first word
// - utopia model: active low, writes every cycle enable stays asserted
// - special select high sends a special code, low a data code, with start of cell and violation low and ten-bit packing off
`timescale 1ns/100ps
module txfp_formatter
  import txfp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic fifoBypassSelect,
  input wire logic encoderBypassSelect,
  input wire logic charWidthSelect,
  input wire logic interfaceConventionSelect,
  input wire logic addressMatchSelectN,
  input wire logic txWriteEnable,
  input wire logic [txfp_pkg::DW-1:0] txData,
  input wire logic specialSelectQualifier,
  input wire logic violationInsertQualifier,
  input wire logic startOfCellQualifier,
  output logic txFifoEmptyFlag,
  output logic txFifoHalfFlag,
  output logic txFifoFullFlag,
  output logic encValid,
  input wire logic encReady,
  output logic [7:0] encData,
  output logic encSpecial
);
  import txfp_pkg::*;

  logic cascade;
  logic enAct;
  logic selected_r;
  logic writeCond;
  logic wrPend_r;
  logic fifoWr;
  logic fifoRd;
  logic [EW-1:0] wrEntry;
  logic [EW-1:0] rdEntry;
  logic rdEmpty;
  logic rawEmpty;
  logic rawHalf;
  logic rawFull;
  logic fmtEn;
  logic packEn;
  logic [2:0] qual;
  txfp_state_t state_r;
  logic [DW-1:0] held_r;
  logic [7:0] acc_r;
  logic [3:0] nb_r;
  logic [15:0] packTmp;
  logic push;
  logic [7:0] pByte;
  logic pSpec;
  logic bufInReady;
  logic [8:0] bufMem [2];
  logic bufWp_r;
  logic bufRp_r;
  logic [1:0] bufCnt_r;
  logic bufPop;

  // write side: polarity and capture timing follow the convention select
  assign cascade = interfaceConventionSelect;
  assign enAct = cascade ? txWriteEnable : !txWriteEnable;
  assign writeCond = fifoBypassSelect && enAct
    && (selected_r || !addressMatchSelectN);
  // cascade writes land one clock late so data trails the enable
  assign fifoWr = cascade ? wrPend_r : writeCond;
  assign wrEntry = {1'b0, startOfCellQualifier, violationInsertQualifier,
    specialSelectQualifier, txData};

  always_ff @(posedge clk)
  begin
    if (!rstn)
      selected_r <= 1'b0;
    else
      selected_r <= enAct && (selected_r || !addressMatchSelectN);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      wrPend_r <= 1'b0;
    else
      wrPend_r <= cascade && writeCond;
  end

  txfp_fifo fifo
  (
    .clk(clk),
    .rstn(rstn),
    .wrEn(fifoWr),
    .wrData(wrEntry),
    .rdEn(fifoRd),
    .rdData(rdEntry),
    .rdEmpty(rdEmpty),
    .emptyFlag(rawEmpty),
    .halfFlag(rawHalf),
    .fullFlag(rawFull)
  );

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      txFifoEmptyFlag <= 1'b0;
      txFifoHalfFlag <= 1'b0;
      txFifoFullFlag <= 1'b0;
    end
    else
    begin
      txFifoEmptyFlag <= cascade ? rawEmpty : !rawEmpty;
      txFifoHalfFlag <= cascade ? rawHalf : !rawHalf;
      txFifoFullFlag <= cascade ? rawFull : !rawFull;
    end
  end

  // read side
  assign fmtEn = fifoBypassSelect && encoderBypassSelect;
  assign packEn = fmtEn && !charWidthSelect;
  assign qual = {rdEntry[F_SOC], rdEntry[F_SC], rdEntry[F_SVS]};
  assign packTmp = ({6'h00, rdEntry[DW-1:0]} << nb_r) | {8'h00, acc_r};

  always_comb
  begin
    push = 1'b0;
    pByte = 8'h00;
    pSpec = 1'b0;
    fifoRd = 1'b0;
    if (fifoBypassSelect && bufInReady)
    begin
      case (state_r)
        ST_FETCH:
          if (packEn)
          begin
            if (nb_r == NB_FULL)
            begin
              push = 1'b1;
              pByte = acc_r;
            end
            else if (!rdEmpty)
            begin
              fifoRd = 1'b1;
              push = 1'b1;
              pByte = packTmp[7:0];
            end
            else if (nb_r != 4'h0)
            begin
              push = 1'b1;
              pByte = acc_r;
            end
          end
          else if (!rdEmpty)
          begin
            fifoRd = 1'b1;
            push = 1'b1;
            pByte = rdEntry[7:0];
            pSpec = rdEntry[F_SC];
            if (fmtEn)
            begin
              case (qual)
                Q_DATA, Q_CMD: pSpec = rdEntry[F_SC];
                Q_SOC:
                begin
                  pByte = CODE_SOC;
                  pSpec = 1'b1;
                end
                Q_EXT:
                begin
                  pByte = CODE_EXT;
                  pSpec = 1'b1;
                end
                Q_ADDR:
                begin
                  pByte = CODE_ADDR;
                  pSpec = 1'b1;
                end
                default:
                begin
                  pByte = CODE_EXC;
                  pSpec = 1'b1;
                end
              endcase
            end
          end
        ST_MARK:
        begin
          push = 1'b1;
          pByte = held_r[7:0];
        end
        ST_FILL:
        begin
          push = 1'b1;
          pByte = CODE_FILL;
          pSpec = 1'b1;
        end
        default:
          push = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= ST_FETCH;
      held_r <= '0;
    end
    else if (push)
    begin
      case (state_r)
        ST_FETCH:
          if (packEn && !fifoRd && nb_r != NB_FULL)
            state_r <= ST_FILL;
          else if (fifoRd && fmtEn && !packEn && qual[2] && qual != 3'h5)
          begin
            state_r <= ST_MARK;
            held_r <= rdEntry[DW-1:0];
          end
        default:
          state_r <= ST_FETCH;
      endcase
    end
  end

  // packer residue; leaving ten-bit mode drops any residue
  always_ff @(posedge clk)
  begin
    if (!rstn || !packEn)
    begin
      nb_r <= 4'h0;
      acc_r <= 8'h00;
    end
    else if (push && state_r == ST_FETCH)
    begin
      if (fifoRd)
      begin
        nb_r <= nb_r + NB_STEP;
        acc_r <= packTmp[15:8];
      end
      else
      begin
        nb_r <= 4'h0;
        acc_r <= 8'h00;
      end
    end
  end

  // two-entry buffer absorbs an encoder stall without losing a byte
  assign bufInReady = (bufCnt_r != BUF_DEPTH);
  assign encValid = (bufCnt_r != 2'h0);
  assign bufPop = encValid && encReady;
  assign encData = bufMem[bufRp_r][7:0];
  assign encSpecial = bufMem[bufRp_r][8];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bufMem[0] <= 9'h000;
      bufMem[1] <= 9'h000;
    end
    else if (push)
      bufMem[bufWp_r] <= {pSpec, pByte};
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bufWp_r <= 1'b0;
      bufRp_r <= 1'b0;
      bufCnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        bufWp_r <= !bufWp_r;
      if (bufPop)
        bufRp_r <= !bufRp_r;
      bufCnt_r <= bufCnt_r + {1'b0, push} - {1'b0, bufPop};
    end
  end

  sequence sPadByte;
    state_r == ST_FETCH && packEn && push && !fifoRd && nb_r != NB_FULL;
  endsequence

  sequence sSocRead;
    fifoRd && fmtEn && !packEn && qual == Q_SOC;
  endsequence

  AST_UTOPIA_WR: assert property (@(posedge clk) disable iff (!rstn)
    !cascade && writeCond && !rawFull
      |=> fifo.wrBin_r == $past(fifo.wrBin_r) + 9'h001)
    else $error("utopia write not taken in its own cycle");

  AST_CASCADE_WR: assert property (@(posedge clk) disable iff (!rstn)
    cascade && writeCond && !fifoWr ##1 cascade |-> fifoWr)
    else $error("cascade write not delayed by one clock");

  AST_EXC: assert property (@(posedge clk) disable iff (!rstn)
    fifoRd && fmtEn && !packEn && qual[0] && qual != Q_ADDR
      |-> pSpec && pByte == CODE_EXC)
    else $error("violation entry not replaced by exception code");

  AST_SOC_MARK: assert property (@(posedge clk) disable iff (!rstn)
    sSocRead |-> pSpec && pByte == CODE_SOC ##1 state_r == ST_MARK)
    else $error("start of cell marker missing");

  AST_MARK_DATA: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_MARK && push |-> !pSpec ##1 state_r == ST_FETCH)
    else $error("character after marker not sent as data");

  AST_NOFMT: assert property (@(posedge clk) disable iff (!rstn)
    fifoRd && !fmtEn |-> pByte == rdEntry[7:0] ##1 state_r == ST_FETCH)
    else $error("qualifiers interpreted with encoder bypassed");

  AST_PACK_WRAP: assert property (@(posedge clk) disable iff (!rstn)
    packEn && push && state_r == ST_FETCH && nb_r == NB_FULL
      |-> !fifoRd ##1 nb_r == 4'h0)
    else $error("packer did not wrap after fifth byte");

  AST_PAD_FILL: assert property (@(posedge clk) disable iff (!rstn)
    sPadByte |-> (pByte >> nb_r) == 8'h00
      ##1 state_r == ST_FILL && nb_r == 4'h0)
    else $error("padded byte not followed by fill");
endmodule

/* tb/txfp_host_model.sv */
// host side writer that drives the transmit write port in either convention
`timescale 1ns/100ps
module txfp_host_model
  import txfp_pkg::*;
(
  input wire logic clk,
  input wire logic cascade,
  output logic addrN,
  output logic wrEn,
  output logic [txfp_pkg::DW-1:0] data,
  output logic sc,
  output logic svs,
  output logic soc
);
  logic act = 1'b0;
  logic [12:0] bus = 13'h0;
  assign wrEn = cascade ? act : !act;
  assign {soc, sc, svs, data} = bus;
  initial addrN = 1'b1;

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // an idle bus shows the inverse of its last value, never a stale copy
  task automatic park();
    bus = ~bus;
  endtask

  // words are {start of cell, special select, violation, data}
  task automatic burst(input logic [12:0] q[$]);
    int i;
    if (cascade)
    begin
      step();
      act = 1'b1;
      addrN = 1'b0;
      park();
      for (i = 0; i < q.size(); i++)
      begin
        step();
        addrN = 1'b1;
        act = (i < q.size() - 1);
        bus = q[i];
      end
      step();
      park();
    end
    else
    begin
      for (i = 0; i < q.size(); i++)
      begin
        step();
        addrN = (i != 0);
        act = 1'b1;
        bus = q[i];
      end
      step();
      act = 1'b0;
      park();
    end
  endtask

  // enable asserted without ever being addressed
  task automatic stray(input int n);
    repeat (n)
    begin
      step();
      act = 1'b1;
      park();
    end
    step();
    act = 1'b0;
  endtask
endmodule

/* tb/txfp_formatter_tb.sv */
// self-checking bench for the transmit fifo, formatter and packer
`timescale 1ns/100ps
module txfp_formatter_tb;
  import txfp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fifoEn = 1'b1;
  logic encEn = 1'b1;
  logic wide8 = 1'b1;
  logic cascade = 1'b0;
  logic encReady = 1'b0;
  logic holdReady = 1'b1;
  logic addrN, wrEn, sc, svs, soc;
  logic [DW-1:0] data;
  logic encValid, encSpecial, emptyF, halfF, fullF;
  logic [7:0] encData;
  int bad_count = 0;
  int n_compared = 0;
  int expQ[$];
  logic [12:0] words[$];
  int sizes[4] = '{9, 2, 3, 8};

  txfp_formatter DUT (.clk(clk), .rstn(rstn), .fifoBypassSelect(fifoEn),
    .encoderBypassSelect(encEn), .charWidthSelect(wide8),
    .interfaceConventionSelect(cascade), .addressMatchSelectN(addrN),
    .txWriteEnable(wrEn), .txData(data), .specialSelectQualifier(sc),
    .violationInsertQualifier(svs), .startOfCellQualifier(soc),
    .txFifoEmptyFlag(emptyF), .txFifoHalfFlag(halfF),
    .txFifoFullFlag(fullF), .encValid(encValid), .encReady(encReady),
    .encData(encData), .encSpecial(encSpecial));

  txfp_host_model host (.clk(clk), .cascade(cascade), .addrN(addrN),
    .wrEn(wrEn), .data(data), .sc(sc), .svs(svs), .soc(soc));

  initial
    forever #5 clk = ~clk;

  always @(posedge clk)
  begin
    #1;
    encReady = !holdReady && ($urandom % 4 != 0);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      bad_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (rstn && encValid === 1'b1 && encReady)
    begin
      if (expQ.size() == 0)
        check({7'h0, encSpecial, encData}, 16'hFFFF);
      else
        check({7'h0, encSpecial, encData}, 16'(expQ.pop_front()));
    end
  end

  // one entry in byte mode; violation wins except on the address marker
  function automatic void expect8(input logic [12:0] w);
    logic [2:0] q;
    q = w[12:10];
    if (!encEn)
      expQ.push_back({w[11], w[7:0]});
    else if (q[0] && q != Q_ADDR)
      expQ.push_back({1'b1, CODE_EXC});
    else if (q[2])
    begin
      expQ.push_back({1'b1, q == Q_SOC ? CODE_SOC :
        q == Q_EXT ? CODE_EXT : CODE_ADDR});
      expQ.push_back({1'b0, w[7:0]});
    end
    else
      expQ.push_back({q[1], w[7:0]});
  endfunction

  // packed stream of the whole burst: lsb first, zero pad, then fill
  function automatic void expect10();
    int acc, nb;
    acc = 0;
    nb = 0;
    foreach (words[i])
    begin
      acc = acc | (int'(words[i][9:0]) << nb);
      nb += 10;
      while (nb >= 8)
      begin
        expQ.push_back(acc & 255);
        acc = acc >> 8;
        nb -= 8;
      end
    end
    if (nb > 0)
    begin
      expQ.push_back(acc & 255);
      expQ.push_back({1'b1, CODE_FILL});
    end
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send(input int n, input bit sweep, input bit doExp);
    words.delete();
    for (int i = 0; i < n; i++)
    begin
      words.push_back({sweep ? 3'(i) : 3'h0, 10'($urandom)});
      if (doExp && wide8)
        expect8(words[i]);
    end
    if (doExp && !wide8)
      expect10();
    host.burst(words);
  endtask

  task automatic flags(input logic e, input logic h, input logic f);
    logic [2:0] want;
    want = cascade ? {e, h, f} : ~{e, h, f};
    check({13'h0, emptyF, halfF, fullF}, {13'h0, want});
  endtask

  task automatic drain();
    int k;
    holdReady = 1'b0;
    for (k = 0; k < 3000 && expQ.size() != 0; k++)
      @(posedge clk);
    tick(8);
    check(16'(expQ.size()), 16'h0);
    check({15'h0, encValid}, 16'h0);
    flags(1'b1, 1'b0, 1'b0);
  endtask

  initial
  begin
    #500000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h4173));
    tick(16);
    rstn = 1'b1;
    tick(4);
    flags(1'b1, 1'b0, 1'b0);
    // every qualifier code, both conventions, encoder on and off
    for (int m = 0; m < 4; m++)
    begin
      cascade = m[0];
      encEn = !m[1];
      tick(4);
      holdReady = 1'b0;
      send(16, 1'b1, 1'b1);
      drain();
    end
    encEn = 1'b1;
    cascade = 1'b0;
    host.stray(5);
    fifoEn = 1'b0;
    send(4, 1'b0, 1'b0);
    tick(10);
    fifoEn = 1'b1;
    tick(4);
    flags(1'b1, 1'b0, 1'b0);
    // packed mode with each possible residue at the end of a burst
    wide8 = 1'b0;
    foreach (sizes[j])
    begin
      holdReady = 1'b1;
      send(sizes[j], 1'b0, 1'b1);
      tick(8);
      drain();
    end
    wide8 = 1'b1;
    cascade = 1'b1;
    holdReady = 1'b1;
    send(140, 1'b0, 1'b1);
    tick(8);
    flags(1'b0, 1'b1, 1'b0);
    drain();
    // overfill in the active low convention; the excess is dropped
    cascade = 1'b0;
    holdReady = 1'b1;
    tick(4);
    send(300, 1'b0, 1'b0);
    tick(8);
    flags(1'b0, 1'b1, 1'b1);
    rstn = 1'b0;
    expQ.delete();
    tick(2);
    rstn = 1'b1;
    tick(4);
    flags(1'b1, 1'b0, 1'b0);
    check({15'h0, encValid}, 16'h0);
    report_and_stop();
  end
endmodule
